// [bench/bps_ext_master.sv]
// External bus master model that drives the pins of the parallel slave port.
// Assumes the port samples its pins on sys_clk and raises oe only while it drives the data bus.
`timescale 1ns/1ns

module bps_ext_master (
    input  wire logic       sys_clk, // System clock.
    input  wire logic [3:0] pol,     // Active levels: bit 3 select, bit 1 write, bit 0 read.
    input  wire logic [7:0] dout,    // Port data drive value.
    input  wire logic       oe,      // Port drives the data bus.
    output logic            cs_pin,  // Chip select pin.
    output logic            rd_pin,  // Read strobe pin.
    output logic            wr_pin,  // Write strobe pin.
    output logic      [1:0] addr,    // Buffer address.
    output logic      [7:0] bus      // Resolved data bus level.
);
    logic       cs_act  = 1'b0;
    logic       rd_act  = 1'b0;
    logic       wr_act  = 1'b0;
    logic       drv     = 1'b0;
    logic [7:0] mdata   = 8'h00;
    logic [7:0] float_q = 8'h5a;

    initial addr = 2'h0;
    assign cs_pin = cs_act ~^ pol[3];
    assign wr_pin = wr_act ~^ pol[1];
    assign rd_pin = rd_act ~^ pol[0];
    // A released bus shows a pattern that changes every cycle, alternating between the complement of the last byte and the byte itself.
    assign bus = oe ? dout : (drv ? mdata : float_q);
    always @(posedge sys_clk) float_q <= ~bus;

    // One byte transfer; address, data and select are set up before the strobe and held past it.
    task automatic xfer(input logic r, input logic w, input logic cs, input logic [1:0] a,
                        input logic [7:0] d, input int hold);
        @(posedge sys_clk);
        cs_act <= cs;
        addr   <= a;
        mdata  <= d;
        drv    <= w;
        @(posedge sys_clk);
        rd_act <= r;
        wr_act <= w;
        repeat (hold) @(posedge sys_clk);
        rd_act <= 1'b0;
        wr_act <= 1'b0;
        @(posedge sys_clk);
        cs_act <= 1'b0;
        drv    <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : xfer
endmodule : bps_ext_master

// [bench/bps_slave_port_test.sv]
// Self-checking bench for the parallel slave port in legacy, buffered and addressable modes.
// Assumes the external master model and the design files are compiled first.
`timescale 1ns/1ns
`include "bps_defines.svh"

module bps_slave_port_test;
    logic        sys_clk     = 1'b0;
    logic        rst         = 1'b1;
    logic        port_enable = 1'b0;
    logic [1:0]  op_mode     = 2'h0;
    logic [1:0]  incm        = 2'h0;
    logic [1:0]  irqm        = 2'h0;
    logic [3:0]  pol         = 4'h0;
    logic        pers        = 1'b0;
    logic        sw_wr       = 1'b0;
    logic [1:0]  sw_idx      = 2'h0;
    logic [7:0]  sw_dat      = 8'h00;
    logic [3:0]  rd_mask     = 4'h0;
    logic        clr         = 1'b0;
    logic        cs_pin, rd_pin, wr_pin, oe, all_e, all_f, unf, ovf, evt;
    logic [1:0]  addr;
    logic [7:0]  bus, dout;
    logic [3:0]  empty, full, e_empty, e_full;
    logic [31:0] in_buf, out_buf, w, exp_in;
    logic [1:0]  a;
    integer      n_errors = 0;
    integer      num_checks = 0;
    integer      cyc = 0;
    integer      seed = 41761;

    always #20 sys_clk = ~sys_clk;

    bps_ext_master bps_ext_master_inst (.sys_clk(sys_clk), .pol(pol), .dout(dout), .oe(oe), .cs_pin(cs_pin),
        .rd_pin(rd_pin), .wr_pin(wr_pin), .addr(addr), .bus(bus));

    bps_slave_port bps_slave_port_inst (.sys_clk(sys_clk), .rst(rst), .port_enable(port_enable),
        .operating_mode(op_mode), .increment_mode_field(incm), .interrupt_mode_field(irqm),
        .port_control_reg(pol), .persistent_variant(pers), .chip_select_pin(cs_pin),
        .read_strobe_pin(rd_pin), .write_strobe_pin(wr_pin), .slave_address_inputs(addr),
        .slave_data_in(bus), .slave_data_out(dout), .slave_data_oe(oe), .sw_out_write(sw_wr),
        .sw_out_index(sw_idx), .sw_out_data(sw_dat), .sw_in_read_mask(rd_mask), .event_clear(clr),
        .underflow_clear(clr), .overflow_clear(clr), .input_buffer_reg(in_buf),
        .output_buffer_reg(out_buf), .output_buf_empty_n(empty), .input_buf_full_n(full),
        .output_all_empty(all_e), .input_all_full(all_f), .output_underflow(unf),
        .input_overflow(ovf), .port_event_flag(evt));

    function automatic logic exp_evt(input logic [1:0] q, input logic [1:0] idx, input logic legacy);
        return legacy | (q == `BPS_IRQM_EVERY) | (q == `BPS_IRQM_BUF3 && idx == `BPS_LAST_BUF);
    endfunction : exp_evt

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // Sets a mode with fresh random polarity, then restarts the buffer logic by an enable edge.
    task automatic set_mode(input logic [1:0] m, input logic [1:0] i, input logic [1:0] q, input logic p);
        @(posedge sys_clk);
        op_mode     <= m;
        incm        <= i;
        irqm        <= q;
        pers        <= p;
        pol         <= 4'($random(seed));
        port_enable <= 1'b0;
        @(posedge sys_clk);
        port_enable <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        e_empty = `BPS_EMPTY_RST;
        e_full  = `BPS_FULL_RST;
    endtask : set_mode

    task automatic sw_op(input logic ld, input logic [1:0] i, input logic [3:0] m, input logic c);
        @(posedge sys_clk);
        sw_wr   <= ld;
        sw_idx  <= i;
        sw_dat  <= w[8*i+:8];
        rd_mask <= m;
        clr     <= c;
        @(posedge sys_clk);
        sw_wr   <= 1'b0;
        rd_mask <= 4'h0;
        clr     <= 1'b0;
        #1;
    endtask : sw_op

    task automatic load_all;
        w = $random(seed);
        for (int i = 0; i < 4; i++) sw_op(1'b1, 2'(i), 4'h0, 1'b0);
        e_empty = 4'h0;
        chk("output_buffer_reg", out_buf, w);
        chk("output_buf_empty_n", 32'(empty), 32'h0);
    endtask : load_all

    task automatic do_rd(input logic [1:0] ad, input logic [1:0] idx, input logic ev);
        sw_op(1'b0, 2'h0, 4'h0, 1'b1);
        fork
            bps_ext_master_inst.xfer(1'b1, 1'b0, 1'b1, ad, 8'h00, 1);
            begin
                repeat (3) @(posedge sys_clk);
                #1;
                chk("slave_data_oe", 32'(oe), 32'h1);
            end
        join
        if (!e_empty[idx]) chk("slave_data_out", 32'(dout), 32'(w[8*idx+:8]));
        chk("output_underflow", 32'(unf), 32'(e_empty[idx]));
        e_empty[idx] = 1'b1;
        chk("output_buf_empty_n", 32'(empty), 32'(e_empty));
        chk("output_all_empty", 32'(all_e), 32'(&e_empty));
        chk("port_event_flag", 32'(evt), 32'(ev));
        chk("slave_data_oe", 32'(oe), 32'h0);
    endtask : do_rd

    task automatic do_wr(input logic [1:0] ad, input logic [1:0] idx, input logic ev);
        logic [7:0] d;
        d = 8'($random(seed));
        sw_op(1'b0, 2'h0, 4'h0, 1'b1);
        bps_ext_master_inst.xfer(1'b0, 1'b1, 1'b1, ad, d, 1);
        if (!e_full[idx]) exp_in[8*idx+:8] = d;
        chk("input_overflow", 32'(ovf), 32'(e_full[idx]));
        e_full[idx] = 1'b1;
        chk("input_buffer_reg", in_buf, exp_in);
        chk("input_buf_full_n", 32'(full), 32'(e_full));
        chk("input_all_full", 32'(all_f), 32'(&e_full));
        chk("port_event_flag", 32'(evt), 32'(ev));
    endtask : do_wr

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            end_sim;
        end
    end

    initial begin
        exp_in = 32'h0;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("output_buf_empty_n", 32'(empty), 32'hf);
        chk("input_buffer_reg", in_buf, 32'h0);
        @(posedge sys_clk);
        rst <= 1'b0;
        set_mode(`BPS_MODE_LEGACY, 2'($random(seed)) & 2'h2, 2'($random(seed)), 1'b0);
        load_all;
        do_wr(2'h3, 2'h0, 1'b1);
        do_rd(2'h2, 2'h0, 1'b1);
        do_rd(2'h0, 2'h0, 1'b1);
        $display("legacy test done");
        for (int q = 0; q < 4; q++) begin
            set_mode(`BPS_MODE_LEGACY, `BPS_INCM_BUFFERED, 2'(q), 1'b0);
            load_all;
            for (int i = 0; i < 5; i++) begin
                do_rd(2'($random(seed)), 2'(i), exp_evt(2'(q), 2'(i), 1'b0));
                do_wr(2'($random(seed)), 2'(i), exp_evt(2'(q), 2'(i), 1'b0));
            end
            sw_op(1'b0, 2'h0, 4'h5, 1'b0);
            chk("input_buf_full_n", 32'(full), 32'ha);
        end
        $display("buffered test done");
        set_mode(`BPS_MODE_ADDR, 2'($random(seed)), `BPS_IRQM_BUF3, 1'b0);
        load_all;
        for (int k = 0; k < 12; k++) begin
            a = 2'($random(seed));
            do_rd(a, a, exp_evt(`BPS_IRQM_BUF3, a, 1'b0));
            do_wr(a, a, exp_evt(`BPS_IRQM_BUF3, a, 1'b0));
        end
        sw_op(1'b0, 2'h0, 4'hf, 1'b1);
        bps_ext_master_inst.xfer(1'b0, 1'b1, 1'b0, 2'h1, 8'h77, 1);
        chk("input_buf_full_n", 32'(full), 32'h0);
        chk("input_buffer_reg", in_buf, exp_in);
        $display("addressable test done");
        set_mode(2'h2, `BPS_INCM_BUFFERED, `BPS_IRQM_EVERY, 1'b0);
        bps_ext_master_inst.xfer(1'b1, 1'b1, 1'b1, 2'h2, 8'h99, 1);
        chk("input_buf_full_n", 32'(full), 32'h0);
        chk("input_buffer_reg", in_buf, exp_in);
        chk("port_event_flag", 32'(evt), 32'h0);
        $display("unselected mode test done");
        for (int p = 0; p < 2; p++) begin
            set_mode(`BPS_MODE_ADDR, 2'h0, `BPS_IRQM_EVERY, 1'(p));
            sw_op(1'b0, 2'h0, 4'h0, 1'b1);
            fork
                bps_ext_master_inst.xfer(1'b0, 1'b1, 1'b1, 2'h0, 8'h3c, 4);
                begin
                    repeat (5) @(posedge sys_clk);
                    #1;
                    chk("port_event_flag", 32'(evt), 32'(p == 0));
                end
            join
            chk("port_event_flag", 32'(evt), 32'h1);
        end
        exp_in[7:0] = 8'h3c;
        $display("write event timing test done");
        set_mode(`BPS_MODE_LEGACY, `BPS_INCM_BUFFERED, `BPS_IRQM_EVERY, 1'b0);
        chk("input_buffer_reg", in_buf, exp_in);
        chk("input_buf_full_n", 32'(full), 32'h0);
        chk("output_buf_empty_n", 32'(empty), 32'hf);
        chk("input_overflow", 32'(ovf), 32'h0);
        $display("enable test done");
        end_sim;
    end
endmodule : bps_slave_port_test

// [design/bps_defines.svh]
// Constants of the buffered parallel slave port: modes, control bit positions, reset values.
// Assumes inclusion by bare name from the package and the port module.
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Mode field encodings
// ----------------------------------------------------------------------------
`define BPS_MODE_LEGACY   2'h0
`define BPS_MODE_ADDR     2'h1
`define BPS_INCM_BUFFERED 2'h3
`define BPS_IRQM_EVERY    2'h1
`define BPS_IRQM_BUF3     2'h2

// ----------------------------------------------------------------------------
// Control register bit positions for strobe and select polarity
// ----------------------------------------------------------------------------
`define BPS_CS_POL_BIT 3
`define BPS_WR_POL_BIT 1
`define BPS_RD_POL_BIT 0

// ----------------------------------------------------------------------------
// Buffer indices and reset values
// ----------------------------------------------------------------------------
`define BPS_LAST_BUF  2'h3
`define BPS_FIRST_BUF 2'h0
`define BPS_EMPTY_RST 4'hf
`define BPS_FULL_RST  4'h0

`endif

// [design/bps_pkg.sv]
// Types of the buffered parallel slave port.
// Assumes nothing beyond the defines header.
`include "bps_defines.svh"

package bps_pkg;

    // ------------------------------------------------------------------------
    // Complete state of the port
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        en_q;
        logic        rd_act_q;
        logic        wr_act_q;
        logic [1:0]  rd_ptr;
        logic [1:0]  wr_ptr;
        logic [31:0] in_buf;
        logic [31:0] out_buf;
        logic [3:0]  out_empty;
        logic [3:0]  in_full;
        logic        all_empty;
        logic        all_full;
        logic        underflow;
        logic        overflow;
        logic        event_flag;
        logic        wr_evt_pend;
        logic [7:0]  data_out;
        logic        data_oe;
    } bps_state_type;

endpackage : bps_pkg

// [design/bps_slave_port.sv]
// Byte-wide parallel slave port with four-byte input and output buffers.
// Assumes pins synchronous to sys_clk and an outside party that resolves the data wire from slave_data_oe.
//
// How it works
// (R1) Legacy mode sets the port event flag on every read and write strobe.
// (R2) Operating mode 00 with increment mode 11 selects buffered mode.
// (R3) Buffer 0 is the lowest byte, buffer 3 the highest byte.
// (R4) Buffered reads drive bytes 0 to 3 in turn, tracked by a read pointer.
// (R5) An output empty flag clears on load and sets once its byte is driven.
// (R6) Buffered read of an empty buffer sets the output underflow flag.
// (R7) Aggregate output empty is set when all four empty flags are set.
// (R8) Buffered writes store bytes 0 to 3 in turn, tracked by a write pointer.
// (R9) An input full flag sets on its write strobe, clears on software read.
// (R10) Buffered write to a full buffer sets overflow and drops the byte.
// (R11) Aggregate input full is set when all four full flags are set.
// (R12) Interrupt mode 01 gives events every strobe, 10 only for buffer 3.
// (R13) Addressable mode selects the buffer directly from the two address inputs.
// (R14) Addressable read drives the byte, sets empty, underflows if already empty.
// (R15) Addressable write stores the byte, sets full, overflows and drops if full.
// (R16) Addressable mode with interrupt mode 10 signals events at address 11.
// (R17) Persistent variant signals write events at strobe end, otherwise at start.
// (R18) Select, write and read polarity come from control bits 3, 1 and 0.
// (R19) Slave modes move bytes only and own the control pins.
// (R20) Events come from the active edge of the master's strobes, except persistent-variant write events, which come at strobe end.
// (R21) The master sets address and select before a strobe and holds them.
// (R22) Enabling resets pointers, empty and full flags, underflow and overflow, but keeps the event flag; disabling keeps buffer contents.
`timescale 1ns/1ns
`include "bps_defines.svh"

module bps_slave_port (
    input  wire logic        sys_clk,              // System clock, 25 MHz.
    input  wire logic        rst,                  // Synchronous reset, active high.
    input  wire logic        port_enable,          // Port on; rising edge restarts buffer logic.
    input  wire logic [1:0]  operating_mode,       // 00 legacy or buffered, 01 addressable.
    input  wire logic [1:0]  increment_mode_field, // 11 with mode 00 gives buffered mode.
    input  wire logic [1:0]  interrupt_mode_field, // 01 every strobe, 10 buffer 3 only.
    input  wire logic [3:0]  port_control_reg,     // Polarity bits 3, 1 and 0.
    input  wire logic        persistent_variant,   // Write event at strobe end when high.
    input  wire logic        chip_select_pin,      // Chip select from the master.
    input  wire logic        read_strobe_pin,      // Read strobe from the master.
    input  wire logic        write_strobe_pin,     // Write strobe from the master.
    input  wire logic [1:0]  slave_address_inputs, // Buffer address in addressable mode.
    input  wire logic [7:0]  slave_data_in,        // Data bus as seen at the pins.
    output logic      [7:0]  slave_data_out,       // Data bus drive value.
    output logic             slave_data_oe,        // High while the port drives the data bus.
    input  wire logic        sw_out_write,         // Software loads one output byte.
    input  wire logic [1:0]  sw_out_index,         // Output byte loaded by software.
    input  wire logic [7:0]  sw_out_data,          // Output byte value.
    input  wire logic [3:0]  sw_in_read_mask,      // Software read of input bytes, one bit each.
    input  wire logic        event_clear,          // Clears the port event flag.
    input  wire logic        underflow_clear,      // Clears the output underflow flag.
    input  wire logic        overflow_clear,       // Clears the input overflow flag.
    output logic      [31:0] input_buffer_reg,     // Four received bytes.
    output logic      [31:0] output_buffer_reg,    // Four bytes to send.
    output logic      [3:0]  output_buf_empty_n,   // Per-buffer output empty flags.
    output logic      [3:0]  input_buf_full_n,     // Per-buffer input full flags.
    output logic             output_all_empty,     // All output buffers empty.
    output logic             input_all_full,       // All input buffers full.
    output logic             output_underflow,     // Sticky output underflow.
    output logic             input_overflow,       // Sticky input overflow.
    output logic             port_event_flag       // Sticky port event.
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [7:0] get_byte(input logic [31:0] word, input logic [1:0] idx);
        get_byte = word[8*idx +: 8]; // R3
    endfunction : get_byte

    function automatic logic [31:0] put_byte(input logic [31:0] word, input logic [1:0] idx,
                                             input logic [7:0] value);
        logic [31:0] tmp;
        tmp = word;
        tmp[8*idx +: 8] = value; // R3
        put_byte = tmp;
    endfunction : put_byte

    function automatic logic event_ok(input logic legacy, input logic [1:0] irqm, input logic [1:0] idx);
        if (legacy) begin
            event_ok = 1'b1; // R1
        end else if (irqm == `BPS_IRQM_EVERY) begin
            event_ok = 1'b1; // R12
        end else if (irqm == `BPS_IRQM_BUF3) begin
            event_ok = (idx == `BPS_LAST_BUF); // R12 R16
        end else begin
            event_ok = 1'b0;
        end
    endfunction : event_ok

    bps_pkg::bps_state_type state_reg;
    bps_pkg::bps_state_type state_next;

    logic       cs_act;
    logic       rd_act;
    logic       wr_act;
    logic       mode_addr;
    logic       mode_buf;
    logic       mode_legacy;
    logic       slave_on;
    logic       enabling;
    logic       rd_go;
    logic       wr_go;
    logic       wr_trail;
    logic [1:0] rd_idx;
    logic [1:0] wr_idx;

    // ------------------------------------------------------------------------
    // Pin qualification and mode decode
    // ------------------------------------------------------------------------
    assign cs_act      = (chip_select_pin == port_control_reg[`BPS_CS_POL_BIT]);  // R18
    assign rd_act      = (read_strobe_pin == port_control_reg[`BPS_RD_POL_BIT]);  // R18
    assign wr_act      = (write_strobe_pin == port_control_reg[`BPS_WR_POL_BIT]); // R18
    assign mode_addr   = (operating_mode == `BPS_MODE_ADDR);
    assign mode_buf    = (operating_mode == `BPS_MODE_LEGACY) &&
                         (increment_mode_field == `BPS_INCM_BUFFERED); // R2
    assign mode_legacy = (operating_mode == `BPS_MODE_LEGACY) && !mode_buf;
    // Slave modes own the pins whenever selected and the port is on.
    assign slave_on    = port_enable && (mode_addr || mode_buf || mode_legacy); // R19
    assign enabling    = port_enable && !state_reg.en_q;
    // The master holds select and address across the strobe, so they are sampled at its leading edge.
    assign rd_go       = slave_on && !enabling && cs_act && rd_act && !state_reg.rd_act_q; // R20 R21
    assign wr_go       = slave_on && !enabling && cs_act && wr_act && !state_reg.wr_act_q; // R20 R21
    assign wr_trail    = state_reg.wr_act_q && !wr_act;
    assign rd_idx      = mode_addr ? slave_address_inputs :
                         (mode_buf ? state_reg.rd_ptr : `BPS_FIRST_BUF); // R13 R4
    assign wr_idx      = mode_addr ? slave_address_inputs :
                         (mode_buf ? state_reg.wr_ptr : `BPS_FIRST_BUF); // R13 R8

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_next          = state_reg;
        state_next.en_q     = port_enable;
        state_next.rd_act_q = rd_act;
        state_next.wr_act_q = wr_act;
        state_next.data_oe  = slave_on && cs_act && rd_act;

        // Software actions come first so that hardware sets below win.
        if (sw_out_write) begin
            state_next.out_buf                 = put_byte(state_reg.out_buf, sw_out_index, sw_out_data);
            state_next.out_empty[sw_out_index] = 1'b0; // R5
        end
        state_next.in_full = state_next.in_full & ~sw_in_read_mask; // R9
        if (underflow_clear) begin
            state_next.underflow = 1'b0;
        end
        if (overflow_clear) begin
            state_next.overflow = 1'b0;
        end
        if (event_clear) begin
            state_next.event_flag = 1'b0;
        end

        if (enabling) begin
            state_next.rd_ptr      = `BPS_FIRST_BUF; // R22
            state_next.wr_ptr      = `BPS_FIRST_BUF;
            state_next.out_empty   = `BPS_EMPTY_RST;
            state_next.in_full     = `BPS_FULL_RST;
            state_next.underflow   = 1'b0;
            state_next.overflow    = 1'b0;
            state_next.wr_evt_pend = 1'b0;
        end

        if (rd_go) begin
            state_next.data_out = get_byte(state_reg.out_buf, rd_idx); // R4 R14
            if (state_reg.out_empty[rd_idx]) begin
                state_next.underflow = 1'b1; // R6 R14
            end
            state_next.out_empty[rd_idx] = 1'b1; // R5 R14
            if (mode_buf) begin
                state_next.rd_ptr = state_reg.rd_ptr + 2'h1; // R4
            end
            if (event_ok(mode_legacy, interrupt_mode_field, rd_idx)) begin
                state_next.event_flag = 1'b1; // R1 R12 R16 R20
            end
        end

        if (wr_go) begin
            if (state_reg.in_full[wr_idx]) begin
                state_next.overflow        = 1'b1; // R10 R15
                // A software read in this cycle loses to the strobe, so the flag stays set.
                state_next.in_full[wr_idx] = 1'b1; // R9
            end else begin
                state_next.in_buf          = put_byte(state_reg.in_buf, wr_idx, slave_data_in); // R8 R15
                state_next.in_full[wr_idx] = 1'b1; // R9 R15
            end
            if (mode_buf) begin
                state_next.wr_ptr = state_reg.wr_ptr + 2'h1; // R8
            end
            if (event_ok(mode_legacy, interrupt_mode_field, wr_idx)) begin
                if (persistent_variant) begin
                    state_next.wr_evt_pend = 1'b1; // R17
                end else begin
                    state_next.event_flag = 1'b1; // R17 R20
                end
            end
        end else if (wr_trail && state_reg.wr_evt_pend) begin
            state_next.event_flag  = 1'b1; // R17
            state_next.wr_evt_pend = 1'b0;
        end

        state_next.all_empty = &state_next.out_empty; // R7
        state_next.all_full  = &state_next.in_full;   // R11
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg           <= '0;
            state_reg.out_empty <= `BPS_EMPTY_RST;
            state_reg.all_empty <= 1'b1;
            state_reg.in_full   <= `BPS_FULL_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign slave_data_out     = state_reg.data_out;
    assign slave_data_oe      = state_reg.data_oe;
    assign input_buffer_reg   = state_reg.in_buf;
    assign output_buffer_reg  = state_reg.out_buf;
    assign output_buf_empty_n = state_reg.out_empty;
    assign input_buf_full_n   = state_reg.in_full;
    assign output_all_empty   = state_reg.all_empty;
    assign input_all_full     = state_reg.all_full;
    assign output_underflow   = state_reg.underflow;
    assign input_overflow     = state_reg.overflow;
    assign port_event_flag    = state_reg.event_flag;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_all_empty_agg: assert property (@(posedge sys_clk) disable iff (rst) // R7
        output_all_empty == (&output_buf_empty_n))
        else $error("aggregate output empty disagrees with buffer flags");

    a_all_full_agg: assert property (@(posedge sys_clk) disable iff (rst) // R11
        input_all_full == (&input_buf_full_n))
        else $error("aggregate input full disagrees with buffer flags");

    a_read_sets_empty: assert property (@(posedge sys_clk) disable iff (rst) // R5
        rd_go |=> output_buf_empty_n[$past(rd_idx)])
        else $error("read did not set the empty flag");

    a_read_underflow: assert property (@(posedge sys_clk) disable iff (rst) // R6
        rd_go && state_reg.out_empty[rd_idx] |=> output_underflow)
        else $error("read of empty buffer did not underflow");

    a_read_drives_byte: assert property (@(posedge sys_clk) disable iff (rst) // R13
        rd_go && mode_addr |=> slave_data_out == get_byte($past(state_reg.out_buf), $past(slave_address_inputs)))
        else $error("addressed read drove the wrong byte");

    a_read_ptr_step: assert property (@(posedge sys_clk) disable iff (rst) // R4
        rd_go && mode_buf |=> state_reg.rd_ptr == $past(state_reg.rd_ptr) + 2'h1)
        else $error("read pointer did not advance");

    a_write_ptr_step: assert property (@(posedge sys_clk) disable iff (rst) // R8
        wr_go && mode_buf |=> state_reg.wr_ptr == $past(state_reg.wr_ptr) + 2'h1)
        else $error("write pointer did not advance");

    a_write_sets_full: assert property (@(posedge sys_clk) disable iff (rst) // R9
        wr_go |=> input_buf_full_n[$past(wr_idx)])
        else $error("write did not set the full flag");

    a_overflow_drop: assert property (@(posedge sys_clk) disable iff (rst) // R10
        wr_go && state_reg.in_full[wr_idx] |=> input_overflow && $stable(input_buffer_reg))
        else $error("write to full buffer not dropped with overflow");

    a_legacy_event: assert property (@(posedge sys_clk) disable iff (rst) // R1
        rd_go && mode_legacy |=> port_event_flag)
        else $error("legacy read gave no event");

    a_buf3_quiet: assert property (@(posedge sys_clk) disable iff (rst) // R12
        rd_go && !wr_go && !wr_trail && mode_buf && interrupt_mode_field == `BPS_IRQM_BUF3 &&
        rd_idx != `BPS_LAST_BUF && !state_reg.event_flag |=> !port_event_flag)
        else $error("event raised for a buffer other than 3");

    a_persist_defer: assert property (@(posedge sys_clk) disable iff (rst) // R17
        wr_go && persistent_variant && event_ok(mode_legacy, interrupt_mode_field, wr_idx) && !rd_go &&
        !state_reg.event_flag
        |=> !port_event_flag && state_reg.wr_evt_pend)
        else $error("persistent write event not deferred");

    a_enable_clear: assert property (@(posedge sys_clk) disable iff (rst) // R22
        enabling |=> input_buf_full_n == `BPS_FULL_RST && output_buf_empty_n == `BPS_EMPTY_RST &&
        !output_underflow && !input_overflow)
        else $error("enable did not clear status");

    a_oe_follows: assert property (@(posedge sys_clk) disable iff (rst) // R18
        slave_data_oe |-> $past(cs_act && rd_act))
        else $error("data driven outside a selected read");

endmodule : bps_slave_port
